// ---- hdl/rotsr_lfsr.sv ----
`timescale 1ns/1ns
`default_nettype none
module rotsr_lfsr (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// generator
	output logic      [15:0] state,
	output logic             bit_out
);
	logic [15:0] lfsr_q;
	logic [15:0] lfsr_d;

	// no enable on purpose: only the system reset controls it
	assign lfsr_d = {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? rotsr_pkg::LFSR_TAPS : 16'h0000);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_q <= rotsr_pkg::LFSR_SEED; // see RQ9
		end else begin
			lfsr_q <= lfsr_d; // see RQ8
		end
	end

	assign state   = lfsr_q;
	assign bit_out = lfsr_q[0];
endmodule : rotsr_lfsr
`default_nettype wire

// ---- hdl/rotsr_pkg.sv ----
// Functional notes
// (RQ1) any write to offset zero starts a whole-device reset; write-only, resets to zero
// (RQ2) scratch registers at offsets one and two store and return eight bits, reset zero
// (RQ3) enable bit n at offset three powers ring inverters 2n and 2n+1
// (RQ4) the tunable ring's output is driven onto its own output pin
// (RQ5) four selector pins choose which ring test reaches the multiplexed output
// (RQ6) codes 1-4,6,7,9,10 pick the listed rings; code 0 gives nothing
// (RQ7) code 5 gives the OR of both 32-stage rings, code 8 their AND
// (RQ8) one pin always carries the output bit of a free-running 16-bit LFSR
// (RQ9) the LFSR returns to its seed only on the system reset
// (RQ10) the PLL's tracked clock and eight-times clock each reach an output pin
// (RQ11) the controller runs the clock at 2 MHz with a 300 kHz PLL reference; CLK_PERIOD_NS and the testbench clock are 50 ns, 20 MHz
// (RQ12) the serial controller uses the system clock as shift clock, 2 MHz rated
// (RQ13) the controller avoids using PLL and serial registers at the same time
// (RQ14) chip select is active low, held for a transfer; shifts ignored while high
// (RQ15) selector codes 11 to 15 leave the multiplexed output inactive
`default_nettype none
package rotsr_pkg;
	// register offsets
	localparam logic [1:0] OFS_RESET_TRIGGER = 2'h0;
	localparam logic [1:0] OFS_SCRATCH_ONE   = 2'h1;
	localparam logic [1:0] OFS_SCRATCH_TWO   = 2'h2;
	localparam logic [1:0] OFS_PAIR_ENABLE   = 2'h3;
	// reset values
	localparam logic [7:0] RST_REG_BYTE      = 8'h00;
	// serial frame: command byte then data byte, msb first
	localparam int unsigned CMD_WRITE_BIT    = 7;
	localparam logic [4:0]  CNT_CMD_LAST     = 5'h07;
	localparam logic [4:0]  CNT_DATA_LAST    = 5'h0f;
	localparam logic [4:0]  CNT_FRAME_DONE   = 5'h10;
	// whole-device reset pulse
	localparam int unsigned CLK_PERIOD_NS    = 50;
	localparam int unsigned CHIP_RST_NS      = 1000;
	localparam int unsigned CHIP_RST_CYC_I   = (CHIP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0]  CHIP_RST_CYC     = 5'(CHIP_RST_CYC_I);
	// lfsr, galois form, maximal polynomial
	localparam logic [15:0] LFSR_SEED        = 16'h0001;
	localparam logic [15:0] LFSR_TAPS        = 16'hb400;
	// selector codes
	localparam logic [3:0] SEL_NO_OSC        = 4'h0;
	localparam logic [3:0] SEL_RING32_A      = 4'h1;
	localparam logic [3:0] SEL_RING32_B      = 4'h2;
	localparam logic [3:0] SEL_RING64        = 4'h3;
	localparam logic [3:0] SEL_RING16        = 4'h4;
	localparam logic [3:0] SEL_DUAL_OR       = 4'h5;
	localparam logic [3:0] SEL_RING31        = 4'h6;
	localparam logic [3:0] SEL_RING128       = 4'h7;
	localparam logic [3:0] SEL_DUAL_AND      = 4'h8;
	localparam logic [3:0] SEL_RING32_D8     = 4'h9;
	localparam logic [3:0] SEL_RING32_D16    = 4'ha;

	typedef struct packed {
		logic       valid;
		logic [1:0] addr;
		logic [7:0] data;
	} rotsr_wreq_t;

	typedef struct packed {
		logic ring32_a;
		logic ring32_b;
		logic ring64;
		logic ring16;
		logic ring31;
		logic ring128;
		logic ring32_d8;
		logic ring32_d16;
	} rotsr_rings_t;
endpackage : rotsr_pkg
`default_nettype wire

// ---- hdl/rotsr_spi_link.sv ----
`timescale 1ns/1ns
`default_nettype none
module rotsr_spi_link (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	// serial pins
	input  wire logic                   cs_n,
	input  wire logic                   mosi,
	output logic                        miso,
	// register side
	output logic                  [1:0] rd_addr,
	input  wire logic             [7:0] rd_data,
	output rotsr_pkg::rotsr_wreq_t      wreq
);
	logic [4:0]             cnt_q;
	logic [4:0]             cnt_d;
	logic [7:0]             sh_q;
	logic [7:0]             rd_sh_q;
	logic                   cmd_wr_q;
	logic [1:0]             cmd_addr_q;
	rotsr_pkg::rotsr_wreq_t wreq_q;
	logic                   at_cmd_last;
	logic                   at_data_last;
	logic                   active;

	// shift clock is clk_sys itself, so mosi is sampled every rising edge
	assign active       = !cs_n && (cnt_q != rotsr_pkg::CNT_FRAME_DONE); // see RQ14
	assign at_cmd_last  = active && (cnt_q == rotsr_pkg::CNT_CMD_LAST);
	assign at_data_last = active && (cnt_q == rotsr_pkg::CNT_DATA_LAST);
	assign cnt_d        = cs_n ? 5'h00 : (active ? cnt_q + 5'h01 : cnt_q);
	// address of the byte being read is complete at the last command bit
	assign rd_addr      = {sh_q[0], mosi};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q      <= 5'h00;
			sh_q       <= 8'h00;
			rd_sh_q    <= 8'h00;
			cmd_wr_q   <= 1'b0;
			cmd_addr_q <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
			if (cs_n) begin
				rd_sh_q <= 8'h00; // see RQ14
			end else if (at_cmd_last) begin
				rd_sh_q <= rd_data;
			end else if (active) begin
				rd_sh_q <= {rd_sh_q[6:0], 1'b0};
			end
			if (active) begin
				sh_q <= {sh_q[6:0], mosi};
			end
			if (at_cmd_last) begin
				cmd_wr_q   <= sh_q[rotsr_pkg::CMD_WRITE_BIT - 1];
				cmd_addr_q <= rd_addr;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wreq_q <= '0;
		end else begin
			wreq_q.valid <= at_data_last && cmd_wr_q;
			wreq_q.addr  <= cmd_addr_q;
			wreq_q.data  <= {sh_q[6:0], mosi};
		end
	end

	assign miso = rd_sh_q[7];
	assign wreq = wreq_q;
endmodule : rotsr_spi_link
`default_nettype wire

// ---- hdl/rotsr_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module rotsr_top (
	// clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	// serial register link
	input  wire logic                    cs_n,
	input  wire logic                    mosi,
	output logic                         miso,
	// oscillator test mux
	input  wire logic              [3:0] oscillator_test_selector,
	input  wire rotsr_pkg::rotsr_rings_t ring_taps,
	output logic                         selected_oscillator_out,
	// tunable ring
	output logic                   [7:0] ring_stage_pair_enable,
	output logic                  [15:0] ring_inverter_enable,
	input  wire logic                    tunable_ring_in,
	output logic                         tunable_oscillator_out,
	// lfsr
	output logic                         lfsr_out,
	// phase-locked loop pins
	input  wire logic                    pll_reference_in,
	output logic                         pll_reference_to_core,
	input  wire logic                    pll_core_tracked,
	input  wire logic                    pll_core_multiplied,
	output logic                         pll_tracked_clock_out,
	output logic                         pll_multiplied_clock_out,
	// whole-device reset request
	output logic                         chip_reset_n_out
);

	////////////////////////////////////////////////////////////////////////////
	// serial link

	rotsr_pkg::rotsr_wreq_t wreq;
	logic             [1:0] rd_addr;
	logic             [7:0] rd_data;

	rotsr_spi_link u_link (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.cs_n    (cs_n),
		.mosi    (mosi),
		.miso    (miso),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.wreq    (wreq)
	);

	////////////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] scratch_one_q;
	logic [7:0] scratch_one_d;
	logic [7:0] scratch_two_q;
	logic [7:0] scratch_two_d;
	logic [7:0] pair_en_q;
	logic [7:0] pair_en_d;
	logic [4:0] rst_cnt_q;
	logic [4:0] rst_cnt_d;
	logic       chip_rst_n_q;
	logic       wr_trigger;
	logic       wr_one;
	logic       wr_two;
	logic       wr_pair;

	assign wr_trigger = wreq.valid && (wreq.addr == rotsr_pkg::OFS_RESET_TRIGGER);
	assign wr_one     = wreq.valid && (wreq.addr == rotsr_pkg::OFS_SCRATCH_ONE);
	assign wr_two     = wreq.valid && (wreq.addr == rotsr_pkg::OFS_SCRATCH_TWO);
	assign wr_pair    = wreq.valid && (wreq.addr == rotsr_pkg::OFS_PAIR_ENABLE);

	// the trigger returns both scratch registers and the pair enable register to reset
	assign scratch_one_d = wr_trigger ? rotsr_pkg::RST_REG_BYTE :
	                       (wr_one ? wreq.data : scratch_one_q); // see RQ2
	assign scratch_two_d = wr_trigger ? rotsr_pkg::RST_REG_BYTE :
	                       (wr_two ? wreq.data : scratch_two_q); // see RQ2
	assign pair_en_d     = wr_trigger ? rotsr_pkg::RST_REG_BYTE :
	                       (wr_pair ? wreq.data : pair_en_q);

	// any value written starts the pulse; a rewrite restarts it
	assign rst_cnt_d = wr_trigger ? rotsr_pkg::CHIP_RST_CYC :
	                   ((rst_cnt_q != 5'h00) ? rst_cnt_q - 5'h01 : 5'h00); // see RQ1

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scratch_one_q <= rotsr_pkg::RST_REG_BYTE;
			scratch_two_q <= rotsr_pkg::RST_REG_BYTE;
			pair_en_q     <= rotsr_pkg::RST_REG_BYTE;
			rst_cnt_q     <= 5'h00;
			chip_rst_n_q  <= 1'b1;
		end else begin
			scratch_one_q <= scratch_one_d;
			scratch_two_q <= scratch_two_d;
			pair_en_q     <= pair_en_d;
			rst_cnt_q     <= rst_cnt_d;
			chip_rst_n_q  <= (rst_cnt_d == 5'h00); // see RQ1
		end
	end

	// trigger register is write-only and reads as zero
	assign rd_data = (rd_addr == rotsr_pkg::OFS_SCRATCH_ONE) ? scratch_one_q :
	                 (rd_addr == rotsr_pkg::OFS_SCRATCH_TWO) ? scratch_two_q :
	                 (rd_addr == rotsr_pkg::OFS_PAIR_ENABLE) ? pair_en_q :
	                 rotsr_pkg::RST_REG_BYTE; // see RQ1

	assign chip_reset_n_out       = chip_rst_n_q;
	assign ring_stage_pair_enable = pair_en_q;

	////////////////////////////////////////////////////////////////////////////
	// tunable ring: one enable bit per inverter pair

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pair
			assign ring_inverter_enable[2*g]   = pair_en_q[g]; // see RQ3
			assign ring_inverter_enable[2*g+1] = pair_en_q[g]; // see RQ3
		end
	endgenerate

	// far too fast to register, so it passes straight through
	assign tunable_oscillator_out = tunable_ring_in; // see RQ4

	////////////////////////////////////////////////////////////////////////////
	// oscillator test mux, combinational on purpose (ring outputs are not
	// sampled by clk_sys); unused codes leave the pin low

	logic sel_hit_a;
	logic sel_hit_b;
	logic sel_hit_64;
	logic sel_hit_16;
	logic sel_hit_31;
	logic sel_hit_128;
	logic sel_hit_d8;
	logic sel_hit_d16;
	logic sel_hit_or;
	logic sel_hit_and;
	logic [3:0] sel;

	assign sel         = oscillator_test_selector; // see RQ5
	assign sel_hit_a   = (sel == rotsr_pkg::SEL_RING32_A);
	assign sel_hit_b   = (sel == rotsr_pkg::SEL_RING32_B);
	assign sel_hit_64  = (sel == rotsr_pkg::SEL_RING64);
	assign sel_hit_16  = (sel == rotsr_pkg::SEL_RING16);
	assign sel_hit_31  = (sel == rotsr_pkg::SEL_RING31);
	assign sel_hit_128 = (sel == rotsr_pkg::SEL_RING128);
	assign sel_hit_d8  = (sel == rotsr_pkg::SEL_RING32_D8);
	assign sel_hit_d16 = (sel == rotsr_pkg::SEL_RING32_D16);
	assign sel_hit_or  = (sel == rotsr_pkg::SEL_DUAL_OR);
	assign sel_hit_and = (sel == rotsr_pkg::SEL_DUAL_AND);

	// and-or tree: codes 0 and 11..15 match nothing and give zero
	assign selected_oscillator_out =
		(sel_hit_a   & ring_taps.ring32_a)                         |
		(sel_hit_b   & ring_taps.ring32_b)                         |
		(sel_hit_64  & ring_taps.ring64)                           |
		(sel_hit_16  & ring_taps.ring16)                           |
		(sel_hit_31  & ring_taps.ring31)                           |
		(sel_hit_128 & ring_taps.ring128)                          |
		(sel_hit_d8  & ring_taps.ring32_d8)                        |
		(sel_hit_d16 & ring_taps.ring32_d16)                       |
		(sel_hit_or  & (ring_taps.ring32_a | ring_taps.ring32_b))  |
		(sel_hit_and & (ring_taps.ring32_a & ring_taps.ring32_b)); // see RQ6 RQ7 RQ15

	////////////////////////////////////////////////////////////////////////////
	// lfsr

	logic [15:0] lfsr_state;

	rotsr_lfsr u_lfsr (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.state   (lfsr_state),
		.bit_out (lfsr_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// phase-locked loop pin routing

	assign pll_reference_to_core    = pll_reference_in;
	assign pll_tracked_clock_out    = pll_core_tracked;    // see RQ10
	assign pll_multiplied_clock_out = pll_core_multiplied; // see RQ10

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_trigger_pulse_len: assert property ( // see RQ1
		wr_trigger |=> (!chip_reset_n_out) [*8]
	) else $error("reset trigger pulse too short");

	a_trigger_pulse_end: assert property ( // see RQ1
		(rst_cnt_q == 5'h01) && !wr_trigger |=> chip_reset_n_out
	) else $error("reset trigger pulse did not end");

	a_trigger_clears_regs: assert property ( // see RQ1
		wr_trigger |=> (scratch_one_q == 8'h00) && (scratch_two_q == 8'h00)
		               && (pair_en_q == 8'h00)
	) else $error("reset trigger left registers set");

	a_trigger_reads_zero: assert property ( // see RQ1
		(rd_addr == rotsr_pkg::OFS_RESET_TRIGGER) |-> (rd_data == 8'h00)
	) else $error("write-only register read nonzero");

	a_scratch_one_store: assert property ( // see RQ2
		wr_one |=> (scratch_one_q == $past(wreq.data))
		           ##1 (scratch_one_q == $past(wreq.data, 2)) || $past(wreq.valid)
	) else $error("scratch one did not keep written value");

	a_scratch_two_hold: assert property ( // see RQ2
		!wreq.valid |=> $stable(scratch_two_q)
	) else $error("scratch two changed without a write");

	a_scratch_readback: assert property ( // see RQ2
		(rd_addr == rotsr_pkg::OFS_SCRATCH_TWO) |-> (rd_data == scratch_two_q)
	) else $error("scratch two read mismatch");

	a_pair_enable_map: assert property ( // see RQ3
		(ring_inverter_enable[1:0] == {2{pair_en_q[0]}})
		&& (ring_inverter_enable[15:14] == {2{pair_en_q[7]}})
	) else $error("inverter pair enable mismatch");

	a_pair_enable_write: assert property ( // see RQ3
		wr_pair && !wr_trigger |=> (ring_stage_pair_enable == $past(wreq.data))
	) else $error("pair enable not written");

	a_tunable_pass: assert property ( // see RQ4
		tunable_oscillator_out == tunable_ring_in
	) else $error("tunable ring output not routed");

	a_mux_dual_or: assert property ( // see RQ7
		(sel == rotsr_pkg::SEL_DUAL_OR) |->
			(selected_oscillator_out == (ring_taps.ring32_a | ring_taps.ring32_b))
	) else $error("code 5 is not the or of both rings");

	a_mux_dual_and: assert property ( // see RQ7
		(sel == rotsr_pkg::SEL_DUAL_AND) |->
			(selected_oscillator_out == (ring_taps.ring32_a & ring_taps.ring32_b))
	) else $error("code 8 is not the and of both rings");

	a_mux_ring_pick: assert property ( // see RQ6
		(sel == rotsr_pkg::SEL_RING128) |-> (selected_oscillator_out == ring_taps.ring128)
	) else $error("code 7 does not pick the 128-stage ring");

	a_mux_idle_codes: assert property ( // see RQ15
		((sel == rotsr_pkg::SEL_NO_OSC) || (sel > rotsr_pkg::SEL_RING32_D16))
			|-> !selected_oscillator_out
	) else $error("idle code drove the mux output");

	a_lfsr_alive: assert property ( // see RQ8
		(lfsr_state != 16'h0000) && (lfsr_out == lfsr_state[0])
		&& (!$past(rst_n) || (lfsr_state != $past(lfsr_state)))
	) else $error("lfsr stalled or output bit wrong");

	a_pll_routing: assert property ( // see RQ10
		(pll_tracked_clock_out == pll_core_tracked)
		&& (pll_multiplied_clock_out == pll_core_multiplied)
	) else $error("pll clock pins not routed");

	a_cs_idle_quiet: assert property ( // see RQ14
		cs_n [*2] |-> !miso && !wreq.valid
	) else $error("link active while chip select high");

	c_reset_trigger: cover property (
		wr_trigger ##1 !chip_reset_n_out
	);

	c_scratch_write: cover property (
		wr_one ##1 (scratch_one_q != 8'h00)
	);

	c_mux_or_code: cover property (
		(sel == rotsr_pkg::SEL_DUAL_OR) && selected_oscillator_out
	);

	c_read_nonzero: cover property (
		!cs_n && miso
	);

endmodule : rotsr_top
`default_nettype wire

// ---- verif/rotsr_spi_ctl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rotsr_spi_ctl_model (
	// clock
	input  wire logic clk_sys,
	// serial pins
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	////////////////////////////////////////////////////////////
	// frames under 16 bits are cut short on purpose to abort
	task automatic xfer(input logic wr, input logic [1:0] addr, input logic [7:0] wd,
			input int nbits, output logic [7:0] rd);
		logic [15:0] frame;
		// ignored command bits set high so a decoder that uses them shows up
		frame = {wr, 5'h1f, addr, wd};
		rd = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			@(negedge clk_sys);
			if (i >= 8)
				rd[15 - i] = miso;
			cs_n = 1'b0;
			mosi = frame[15 - i];
		end
		@(negedge clk_sys);
		cs_n = 1'b1;
		// no pull on this line: invert rather than leave a stale bit
		mosi = ~mosi;
		@(negedge clk_sys);
	endtask : xfer
endmodule : rotsr_spi_ctl_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [3:0] sel;
		logic [7:0] taps;
		logic       exp;
	} rotsr_tb_row_t;
	localparam rotsr_tb_row_t ROWS [28] = '{
		'{4'h0, 8'hff, 1'b0}, '{4'h1, 8'h80, 1'b1}, '{4'h1, 8'h7f, 1'b0}, '{4'h2, 8'h40, 1'b1},
		'{4'h2, 8'hbf, 1'b0}, '{4'h3, 8'h20, 1'b1}, '{4'h3, 8'hdf, 1'b0}, '{4'h4, 8'h10, 1'b1},
		'{4'h4, 8'hef, 1'b0}, '{4'h5, 8'h80, 1'b1}, '{4'h5, 8'h40, 1'b1}, '{4'h5, 8'h3f, 1'b0},
		'{4'h6, 8'h08, 1'b1}, '{4'h6, 8'hf7, 1'b0}, '{4'h7, 8'h04, 1'b1}, '{4'h7, 8'hfb, 1'b0},
		'{4'h8, 8'hc0, 1'b1}, '{4'h8, 8'h80, 1'b0}, '{4'h8, 8'h40, 1'b0}, '{4'h9, 8'h02, 1'b1},
		'{4'h9, 8'hfd, 1'b0}, '{4'ha, 8'h01, 1'b1}, '{4'ha, 8'hfe, 1'b0}, '{4'hb, 8'hff, 1'b0},
		'{4'hc, 8'hff, 1'b0}, '{4'hd, 8'hff, 1'b0}, '{4'he, 8'hff, 1'b0}, '{4'hf, 8'hff, 1'b0}};
	localparam logic [7:0] ENS [2] = '{8'h81, 8'h5a};

	logic                    clk_sys;
	logic                    rst_n;
	logic                    cs_n;
	logic                    mosi;
	logic                    miso;
	logic              [3:0] sel;
	rotsr_pkg::rotsr_rings_t taps;
	logic                    sel_out;
	logic              [7:0] pair_en;
	logic             [15:0] inv_en;
	logic             [15:0] inv_exp;
	logic              [3:0] pins;
	logic              [3:0] pins_out;
	logic                    lfsr_out;
	logic                    chip_rst_n;
	logic              [7:0] rd;
	int                      err_count;
	int                      n_checks;
	int                      cnt;

	rotsr_top dut (
		.clk_sys                  (clk_sys),
		.rst_n                    (rst_n),
		.cs_n                     (cs_n),
		.mosi                     (mosi),
		.miso                     (miso),
		.oscillator_test_selector (sel),
		.ring_taps                (taps),
		.selected_oscillator_out  (sel_out),
		.ring_stage_pair_enable   (pair_en),
		.ring_inverter_enable     (inv_en),
		.tunable_ring_in          (pins[3]),
		.tunable_oscillator_out   (pins_out[3]),
		.lfsr_out                 (lfsr_out),
		.pll_reference_in         (pins[2]),
		.pll_reference_to_core    (pins_out[2]),
		.pll_core_tracked         (pins[1]),
		.pll_core_multiplied      (pins[0]),
		.pll_tracked_clock_out    (pins_out[1]),
		.pll_multiplied_clock_out (pins_out[0]),
		.chip_reset_n_out         (chip_rst_n)
	);

	rotsr_spi_ctl_model u_ctl (
		.clk_sys (clk_sys),
		.cs_n    (cs_n),
		.mosi    (mosi),
		.miso    (miso)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic print_verdict();
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		u_ctl.xfer(1'b1, a, d, 16, rd);
	endtask : wr

	task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
		u_ctl.xfer(1'b0, a, 8'h00, 16, rd);
		chk(16'(rd), 16'(e));
	endtask : rdchk

	// reset is taken directly, so the seed must show in the very first cycle
	task automatic lfsr_trace();
		logic [15:0] m;
		logic [47:0] seen;
		logic [47:0] want;
		logic        hit;
		m = rotsr_pkg::LFSR_SEED;
		for (int i = 0; i < 48; i++) begin
			want[i] = m[0];
			m = m[0] ? ((m >> 1) ^ rotsr_pkg::LFSR_TAPS) : (m >> 1);
			seen[i] = lfsr_out;
			@(negedge clk_sys);
		end
		hit = (seen === want);
		chk(16'(hit), 16'h0001);
	endtask : lfsr_trace
	////////////////////////////////////////////////////////////
	initial begin
		#(50 * 20000);
		err_count++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		sel = 4'h0;
		taps = 8'h00;
		pins = 4'h0;
		err_count = 0;
		n_checks = 0;
		repeat (6) @(negedge clk_sys);
		chk(16'(miso), 16'h0000);
		chk(16'(pair_en), 16'(rotsr_pkg::RST_REG_BYTE));
		chk(inv_en, 16'h0000);
		chk(16'(chip_rst_n), 16'h0001);
		chk(16'(lfsr_out), 16'h0001);
		rst_n = 1'b1;
		lfsr_trace();
		foreach (ROWS[i]) begin
			sel = ROWS[i].sel;
			taps = ROWS[i].taps;
			@(posedge clk_sys);
			chk(16'(sel_out), 16'(ROWS[i].exp));
			@(negedge clk_sys);
		end
		for (int v = 0; v < 16; v++) begin
			pins = 4'(v);
			@(posedge clk_sys);
			chk(16'(pins_out), 16'(v));
			@(negedge clk_sys);
		end
		// loop pins held still from here on while the serial link is busy
		rdchk(2'h1, 8'h00);
		rdchk(2'h2, 8'h00);
		wr(2'h1, 8'ha5);
		wr(2'h2, 8'h5a);
		rdchk(2'h1, 8'ha5);
		rdchk(2'h2, 8'h5a);
		u_ctl.xfer(1'b1, 2'h1, 8'h3c, 12, rd);
		rdchk(2'h1, 8'ha5);
		foreach (ENS[j]) begin
			wr(2'h3, ENS[j]);
			for (int n = 0; n < 8; n++)
				inv_exp[2 * n +: 2] = {2{ENS[j][n]}};
			chk(16'(pair_en), 16'(ENS[j]));
			chk(inv_en, inv_exp);
			rdchk(2'h3, ENS[j]);
		end
		wr(2'h0, 8'h3c);
		cnt = 0;
		while (chip_rst_n !== 1'b0 && cnt < 4) begin
			@(negedge clk_sys);
			cnt++;
		end
		chk(16'(pair_en), 16'h0000);
		cnt = 0;
		while (chip_rst_n === 1'b0 && cnt < 100) begin
			@(negedge clk_sys);
			cnt++;
		end
		chk(16'(cnt), 16'(rotsr_pkg::CHIP_RST_CYC));
		rdchk(2'h0, 8'h00);
		rdchk(2'h1, 8'h00);
		rdchk(2'h2, 8'h00);
		wr(2'h2, 8'h11);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(16'(lfsr_out), 16'h0001);
		rst_n = 1'b1;
		lfsr_trace();
		rdchk(2'h2, 8'h00);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
